/* File: core/seq_cfg.svh */
// Offsets, field positions, reset values and sizes of the sequencer status/DMA block.
// Assumes inclusion by bare name; definitions only.
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

`define OFS_STATUS    12'h124
`define OFS_NUM_CONV  12'h12c
`define OFS_TALLY     12'h130
`define OFS_FILL      12'h134
`define OFS_BUF_BASE  12'h140
`define OFS_BUF_LEN   12'h144
`define OFS_WPTR      12'h148
`define OFS_STAT_BASE 12'h14c
`define OFS_CONTROL   12'h150
`define OFS_CHANNELS  12'h154

`define CTL_IU_EN     0
`define CTL_FRAME     2
`define CTL_START     3
`define CTL_DMA_EN    16
`define CTL_STAT_EN   18

`define ST_CAUSE_LO   20
`define ST_DMA_ERR    18
`define ST_DMA_BSY    17
`define ST_DMA_IDLE   16
`define ST_FRAME_ERR  6
`define ST_CNV_ERR    5
`define ST_FIFO_OF    4
`define ST_CNV_ACT    2
`define ST_IU_IDLE    0

`define SW_CAUSE_LO   28
`define CNT_W         28
`define NUM_ADC       4
`define FIFO_AW       15
`define FIFO_BYTES    32'h0001_0000
`define SAMPLE_BYTES  2
`define RST_ZERO      32'h0000_0000

`endif

/* File: core/seq_pkg.sv */
// Types shared by the sequencer status/DMA block.
// Assumes seq_cfg.svh is compiled alongside.
package seq_pkg;
  typedef enum logic [2:0] {I_OFF, I_IDLE, I_WAIT, I_CONV, I_COLLECT, I_STORE, I_HALT} iu_state_t;
  typedef enum logic [2:0] {D_OFF, D_IDLE, D_RUN, D_LOAD, D_WRITE, D_STATUS, D_ERR} dma_state_t;
  typedef logic [17:0] fifo_word_t;
endpackage

/* File: core/fifo_ram.sv */
// Storage array for the sample FIFO, one write and one registered read port.
// Assumes pointers and full/empty are kept by the instantiating module.
`timescale 1ns/1ps
`include "seq_cfg.svh"
module fifo_ram
  import seq_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                we_i,
  input  wire logic [`FIFO_AW-1:0] waddr_i,
  input  wire fifo_word_t          wdata_i,
  input  wire logic                re_i,
  input  wire logic [`FIFO_AW-1:0] raddr_i,
  output fifo_word_t               rdata_o
);
  fifo_word_t mem [0:(1<<`FIFO_AW)-1];
  fifo_word_t rdata_q;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (re_i) begin
      rdata_q <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule

/* File: core/adc_seq_dma.sv */
// Sequencer input unit, sample FIFO and bus-master DMA with Wishbone registers.
// Assumes inputs synchronous to clk_i; PCI master handshake by an outside bus unit.
`timescale 1ns/1ps
`include "seq_cfg.svh"

// How it works
// - Length write clears the three cause bits; termination sets them.
// - Input error before count reached sets the abort cause.
// - Block end cause on count reached, or next trigger in continuous frames.
// - Exhausted buffer sets buffer end cause; transfers wait for a new buffer.
// - PCI abort sets DMA error and stops; only disabling clears it.
// - Busy while transferring, idle while idle; disable clears idle.
// - Trigger before frame count completes sets frame error and halts.
// - Conversion clock during a running conversion sets conversion error and halts.
// - Store into full FIFO sets overflow and halts the input unit.
// - Active flag sets on start or trigger, clears when count finishes.
// - Input unit idle flag shows idle state, cleared when disabled.
// - Normal mode runs the programmed event count per start; zero is continuous.
// - Frame mode runs the count after each trigger; zero is continuous.
// - Each event converts active channels from 0 upward, devices in parallel.
// - Each event becomes one conversion pulse per active channel per device.
// - A 28-bit wrapping tally counts completed events.
// - Tally clears on normal start and on each trigger without frame error.
// - FIFO of 64 KB reports its fill in bytes, two per sample.
// - Base address is captured when the length is written.
// - Length write starts a transfer only when idle and length nonzero.
// - The next write address is readable.
// - Status word holds cause in 30:28 and bytes in 27:0.
// - Status word is written only when its enable is set.
// - Disabling the DMA engine resets it once any pending PCI write is answered.
// - Disabling the input unit resets it.
module adc_seq_dma
  import seq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        conv_clk_i,
  input  wire logic        frame_trig_i,
  input  wire logic        adc_done_i,
  input  wire logic [63:0] adc_data_i,
  output logic      [3:0]  adc_conv_o,
  output logic             pci_req_o,
  output logic      [31:0] pci_addr_o,
  output logic      [31:0] pci_data_o,
  output logic      [3:0]  pci_be_o,
  input  wire logic        pci_ack_i,
  input  wire logic        pci_abort_i
);
  localparam logic [15:0] DEPTH = 16'(`FIFO_BYTES / `SAMPLE_BYTES);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic dev_on(input logic [3:0] ch, input logic [15:0] cfg,
                                  input logic [1:0] d);
    return ch < cfg[4*d +: 4];
  endfunction

  logic [31:0]         ctl_q, base_q, len_q, sbase_q, ptr_q, dat_q;
  logic [`CNT_W-1:0]   target_q, tally_q, rem_q, xfer_q, xfer_nx;
  logic [15:0]         chan_q, wp_q, rp_q, entries;
  logic [16:0]         fill_q;
  logic [63:0]         samp_q;
  logic [3:0]          ch_q, max_ch, adc_conv_q;
  logic [1:0]          dev_q, tag_q, tag_set;
  logic [2:0]          cause_q, cause_set;
  logic                ack_q, act_q, fr_err_q, cnv_err_q, of_q, err_q;
  logic                req_q;
  logic [31:0]         addr_q, pdat_q;
  logic [3:0]          be_q;
  iu_state_t           iu_st;
  dma_state_t          dma_st;
  fifo_word_t          rd_word, wr_word;

  wire acc      = cyc_i && stb_i && !ack_q;
  // Writes land at the edge where the master sees ack, as classic cycles expect
  wire wr       = cyc_i && stb_i && we_i && ack_q;
  wire start_pulse = wr && adr_i == `OFS_CONTROL && sel_i[0] && dat_i[`CTL_START];
  wire len_wr   = wr && adr_i == `OFS_BUF_LEN;
  wire [31:0] len_new = merge(len_q, dat_i, sel_i) & 32'h0fff_ffff;
  wire iu_en    = ctl_q[`CTL_IU_EN];
  wire frame    = ctl_q[`CTL_FRAME];
  wire dma_en   = ctl_q[`CTL_DMA_EN];
  wire stat_en  = ctl_q[`CTL_STAT_EN];

  // Register writes; start is a write-one pulse and never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q    <= `RST_ZERO;
      target_q <= '0;
      base_q   <= `RST_ZERO;
      len_q    <= `RST_ZERO;
      sbase_q  <= `RST_ZERO;
      chan_q   <= '0;
    end else if (wr) begin
      unique case (adr_i)
        `OFS_CONTROL:   ctl_q <= merge(ctl_q, dat_i, sel_i) & 32'h0005_0005;
        `OFS_NUM_CONV:  target_q <= `CNT_W'(merge({4'h0, target_q}, dat_i, sel_i));
        `OFS_BUF_BASE:  base_q <= merge(base_q, dat_i, sel_i);
        `OFS_BUF_LEN:   len_q <= len_new;
        `OFS_STAT_BASE: sbase_q <= merge(sbase_q, dat_i, sel_i);
        `OFS_CHANNELS:  chan_q <= 16'(merge({16'h0, chan_q}, dat_i, sel_i));
        default: ;
      endcase
    end
  end

  logic [31:0] status;
  always_comb begin
    status = `RST_ZERO;
    status[`ST_CAUSE_LO +: 3] = cause_q;
    status[`ST_DMA_ERR]   = err_q;
    status[`ST_DMA_BSY]   = dma_st inside {D_RUN, D_LOAD, D_WRITE, D_STATUS};
    status[`ST_DMA_IDLE]  = dma_st == D_IDLE;
    status[`ST_FRAME_ERR] = fr_err_q;
    status[`ST_CNV_ERR]   = cnv_err_q;
    status[`ST_FIFO_OF]   = of_q;
    status[`ST_CNV_ACT]   = act_q;
    status[`ST_IU_IDLE]   = iu_st == I_IDLE;
  end

  // Every access answers one cycle later; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= `RST_ZERO;
    end else begin
      ack_q <= acc;
      if (acc && !we_i) begin
        unique case (adr_i)
          `OFS_STATUS:    dat_q <= status;
          `OFS_NUM_CONV:  dat_q <= {4'h0, target_q};
          `OFS_TALLY:     dat_q <= {4'h0, tally_q};
          `OFS_FILL:      dat_q <= {15'h0, fill_q};
          `OFS_BUF_BASE:  dat_q <= base_q;
          `OFS_BUF_LEN:   dat_q <= len_q;
          `OFS_WPTR:      dat_q <= ptr_q;
          `OFS_STAT_BASE: dat_q <= sbase_q;
          `OFS_CONTROL:   dat_q <= ctl_q;
          `OFS_CHANNELS:  dat_q <= {16'h0, chan_q};
          default:        dat_q <= `RST_ZERO;
        endcase
      end
    end
  end

  always_comb begin
    max_ch = 4'h0;
    for (int i = 0; i < `NUM_ADC; i++) begin
      if (chan_q[4*i +: 4] > max_ch) max_ch = chan_q[4*i +: 4];
    end
  end

  // Input unit decisions
  wire fifo_full  = entries == DEPTH;
  wire fifo_empty = entries == 16'h0;
  wire busy_cv    = iu_st inside {I_CONV, I_COLLECT, I_STORE};
  wire running    = busy_cv || iu_st == I_WAIT;
  wire samp_on    = iu_st == I_STORE && dev_on(ch_q, chan_q, dev_q);
  wire cnv_err_now = conv_clk_i && busy_cv;
  wire of_err_now  = samp_on && fifo_full;
  wire fr_err_now  = frame_trig_i && frame && running && target_q != '0;
  wire fr_end_now  = frame_trig_i && frame && running && target_q == '0;
  wire halt_now    = cnv_err_now || of_err_now || fr_err_now;
  wire samp_we     = samp_on && !fifo_full;
  wire last_dev    = dev_q == 2'(`NUM_ADC - 1);
  wire evt_done    = !halt_now && ((iu_st == I_STORE && last_dev && ch_q + 4'h1 >= max_ch)
                     || (iu_st == I_WAIT && conv_clk_i && max_ch == 4'h0));
  wire last_evt    = target_q != '0 && tally_q + 28'h1 == target_q;
  wire go_normal   = iu_st == I_IDLE && !frame && start_pulse;
  wire go_frame    = frame && frame_trig_i && (iu_st == I_IDLE || running) && !fr_err_now;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iu_st <= I_OFF;
    end else if (!iu_en) begin
      iu_st <= I_OFF;
    end else if (halt_now) begin
      iu_st <= I_HALT;
    end else begin
      unique case (iu_st)
        I_OFF:     iu_st <= I_IDLE;
        I_IDLE:    if (go_normal || go_frame) iu_st <= I_WAIT;
        I_WAIT:    if (conv_clk_i) iu_st <= evt_done ? (last_evt ? I_IDLE : I_WAIT) : I_CONV;
        I_CONV:    iu_st <= I_COLLECT;
        I_COLLECT: if (adc_done_i) iu_st <= I_STORE;
        I_STORE:   if (last_dev) iu_st <= evt_done ? (last_evt ? I_IDLE : I_WAIT) : I_CONV;
        I_HALT:    iu_st <= I_HALT;
      endcase
    end
  end

  // Channel walk: devices stored in order per channel, channels ascending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_q   <= 4'h0;
      dev_q  <= 2'h0;
      samp_q <= '0;
    end else begin
      if (iu_st == I_WAIT) ch_q <= 4'h0;
      if (iu_st == I_COLLECT && adc_done_i) begin
        samp_q <= adc_data_i;
        dev_q  <= 2'h0;
      end
      if (iu_st == I_STORE) begin
        dev_q <= dev_q + 2'h1;
        if (last_dev) ch_q <= ch_q + 4'h1;
      end
    end
  end

  // One pulse per active channel per device, all devices together
  for (genvar g = 0; g < `NUM_ADC; g++) begin : g_conv
    always_ff @(posedge clk_i) begin
      if (rst_i) adc_conv_q[g] <= 1'b0;
      else adc_conv_q[g] <= iu_st == I_CONV && dev_on(ch_q, chan_q, 2'(g));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tally_q <= '0;
      act_q   <= 1'b0;
    end else if (iu_st == I_OFF) begin
      act_q <= 1'b0;
    end else begin
      if (go_normal || go_frame) tally_q <= '0;
      else if (evt_done) tally_q <= tally_q + 28'h1;
      if (go_normal || go_frame) act_q <= 1'b1;
      else if (evt_done && last_evt) act_q <= 1'b0;
    end
  end

  // Error flags: set wins; cleared only by disabling the input unit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fr_err_q  <= 1'b0;
      cnv_err_q <= 1'b0;
      of_q      <= 1'b0;
    end else begin
      fr_err_q  <= (iu_en && fr_err_q) || fr_err_now;
      cnv_err_q <= (iu_en && cnv_err_q) || cnv_err_now;
      of_q      <= (iu_en && of_q) || of_err_now;
    end
  end

  // Markers ride in the FIFO so causes line up with the data that precedes them
  assign tag_set = {halt_now && act_q, (evt_done && last_evt) || (fr_end_now && !halt_now)};
  wire tag_we = tag_q != 2'h0 && !samp_we && !fifo_full;
  always_ff @(posedge clk_i) begin
    if (rst_i) tag_q <= 2'h0;
    else tag_q <= (tag_we ? 2'h0 : tag_q) | tag_set;
  end

  assign wr_word = samp_we ? {2'b00, samp_q[16*dev_q +: 16]} : {tag_q, 16'h0};
  wire rd_en = dma_st == D_RUN && !fifo_empty;
  wire rd_tag = rd_word[17:16] != 2'h0;
  assign entries = wp_q - rp_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q   <= 16'h0;
      rp_q   <= 16'h0;
      fill_q <= 17'h0;
    end else begin
      if (samp_we || tag_we) wp_q <= wp_q + 16'h1;
      if (rd_en) rp_q <= rp_q + 16'h1;
      unique case ({samp_we, dma_st == D_LOAD && !rd_tag})
        2'b10:   fill_q <= fill_q + 17'(`SAMPLE_BYTES);
        2'b01:   fill_q <= fill_q - 17'(`SAMPLE_BYTES);
        default: fill_q <= fill_q;
      endcase
    end
  end

  fifo_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (samp_we || tag_we),
    .waddr_i (wp_q[`FIFO_AW-1:0]),
    .wdata_i (wr_word),
    .re_i    (rd_en),
    .raddr_i (rp_q[`FIFO_AW-1:0]),
    .rdata_o (rd_word)
  );

  // DMA engine
  wire len_ok   = len_wr && dma_st == D_IDLE && len_new != `RST_ZERO;
  wire buf_end  = dma_st == D_WRITE && pci_ack_i && rem_q < 28'h4;
  wire term     = (dma_st == D_LOAD && rd_tag) || buf_end;
  wire abort_in = pci_abort_i && (dma_st == D_WRITE || dma_st == D_STATUS);
  wire [2:0] cause_all = cause_q | cause_set;
  assign cause_set = {(dma_st == D_LOAD && rd_tag) ? rd_word[17:16] : 2'h0, buf_end};
  assign xfer_nx = (dma_st == D_WRITE && pci_ack_i) ? xfer_q + 28'h2 : xfer_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_st <= D_OFF;
    end else if (!dma_en && !(dma_st inside {D_WRITE, D_STATUS})) begin
      dma_st <= D_OFF;
    end else begin
      unique case (dma_st)
        D_OFF:    dma_st <= D_IDLE;
        D_IDLE:   if (len_ok) dma_st <= D_RUN;
        D_RUN:    if (rd_en) dma_st <= D_LOAD;
        D_LOAD:   dma_st <= rd_tag ? (stat_en ? D_STATUS : D_IDLE) : D_WRITE;
        D_WRITE:  begin
          if (pci_abort_i) dma_st <= D_ERR;
          else if (buf_end) dma_st <= stat_en ? D_STATUS : D_IDLE;
          else if (pci_ack_i) dma_st <= D_RUN;
        end
        D_STATUS: begin
          if (pci_abort_i) dma_st <= D_ERR;
          else if (pci_ack_i) dma_st <= D_IDLE;
        end
        D_ERR:    dma_st <= D_ERR;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q  <= `RST_ZERO;
      rem_q  <= '0;
      xfer_q <= '0;
    end else if (len_ok) begin
      ptr_q  <= base_q;
      rem_q  <= len_new[`CNT_W-1:0];
      xfer_q <= '0;
    end else if (dma_st == D_WRITE && pci_ack_i) begin
      ptr_q  <= ptr_q + 32'(`SAMPLE_BYTES);
      rem_q  <= rem_q - 28'(`SAMPLE_BYTES);
      xfer_q <= xfer_nx;
    end
  end

  // Cause and error: a setting event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= 3'h0;
      err_q   <= 1'b0;
    end else begin
      cause_q <= (len_wr ? 3'h0 : cause_q) | cause_set;
      err_q   <= (dma_en && err_q) || abort_in;
    end
  end

  // Master request holds until the bus unit answers with ack or abort
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q  <= 1'b0;
      addr_q <= `RST_ZERO;
      pdat_q <= `RST_ZERO;
      be_q   <= 4'h0;
    end else if (dma_st == D_LOAD && !rd_tag) begin
      req_q  <= 1'b1;
      addr_q <= {ptr_q[31:2], 2'b00};
      pdat_q <= {2{rd_word[15:0]}};
      be_q   <= ptr_q[1] ? 4'hc : 4'h3;
    end else if (term && stat_en) begin
      req_q  <= 1'b1;
      addr_q <= sbase_q;
      pdat_q <= {1'b0, cause_all, xfer_nx};
      be_q   <= 4'hf;
    end else if (pci_ack_i || pci_abort_i) begin
      req_q  <= 1'b0;
    end
  end

  assign dat_o      = dat_q;
  assign ack_o      = ack_q;
  assign adc_conv_o = adc_conv_q;
  assign pci_req_o  = req_q;
  assign pci_addr_o = addr_q;
  assign pci_data_o = pdat_q;
  assign pci_be_o   = be_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_evt_start;
    iu_st == I_WAIT && conv_clk_i && max_ch != 4'h0 && !halt_now && iu_en;
  endsequence
  sequence s_pulse_out;
    iu_st == I_CONV ##1 adc_conv_q != 4'h0;
  endsequence

  a_ack_single:   assert property (ack_q |=> !ack_q) else $error("ack held two cycles");
  a_conv_pulse:   assert property (s_evt_start |=> s_pulse_out)
    else $error("no conversion pulse after event");
  a_cnv_halt:     assert property (cnv_err_now && iu_en |=> cnv_err_q && iu_st == I_HALT)
    else $error("conversion overrun not halted");
  a_frame_halt:   assert property (fr_err_now && iu_en |=> fr_err_q && iu_st == I_HALT)
    else $error("frame overrun not halted");
  a_of_halt:      assert property (of_err_now && iu_en |=> of_q && iu_st == I_HALT)
    else $error("overflow not halted");
  a_start_tally:  assert property (go_normal && iu_en |=> tally_q == '0 && act_q)
    else $error("normal start did not clear tally");
  a_len_start:    assert property (len_ok && dma_en |=> dma_st == D_RUN
                    && ptr_q == $past(base_q)) else $error("buffer not started from base");
  a_cause_clear:  assert property (len_wr && dma_st == D_IDLE |=> cause_q == 3'h0)
    else $error("cause not cleared by length write");
  a_ptr_step:     assert property (dma_st == D_WRITE && pci_ack_i && !len_ok
                    |=> ptr_q == $past(ptr_q) + 32'h2) else $error("pointer did not advance");
  a_abort_stop:   assert property (pci_abort_i && dma_st == D_WRITE
                    |=> err_q && dma_st == D_ERR) else $error("abort did not stop engine");
  a_buf_end:      assert property (buf_end |=> cause_q[0] && dma_st != D_RUN)
    else $error("buffer end not reported");
endmodule

/* File: dv/host_ram_model.sv */
// Host memory seen as a PCI write target, answering after a random wait.
// Assumes the block holds each request until it sees ack or abort.
`timescale 1ns/1ps
module host_ram_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] data_i,
  input  wire logic        abort_en_i,
  input  wire logic [31:0] stat_base_i,
  output logic             ack_o,
  output logic             abort_o,
  output logic      [31:0] stat_word_o,
  output int               stat_writes_o,
  output int               sample_writes_o
);
  int wait_q;

  // Random wait exercises both prompt and slow targets
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    abort_o <= 1'b0;
    if (rst_i) begin
      wait_q <= 0;
      stat_word_o <= '0;
      stat_writes_o <= 0;
      sample_writes_o <= 0;
    end else if (req_i && !ack_o && !abort_o) begin
      if (wait_q != 0) begin
        wait_q <= wait_q - 1;
      end else begin
        wait_q <= $urandom_range(3, 0);
        if (abort_en_i) begin
          abort_o <= 1'b1;
        end else if (addr_i == stat_base_i) begin
          ack_o <= 1'b1;
          stat_word_o <= data_i;
          stat_writes_o <= stat_writes_o + 1;
        end else begin
          ack_o <= 1'b1;
          sample_writes_o <= sample_writes_o + 1;
        end
      end
    end
  end
endmodule

/* File: dv/adc_seq_dma_tb_top.sv */
// Self-checking bench: registers, a counted run, buffer end, PCI abort, input faults.
// Assumes ADC results arrive one cycle after each conversion pulse.
`timescale 1ns/1ps
`include "seq_cfg.svh"
module adc_seq_dma_tb_top;
  import seq_pkg::*;
  localparam logic [31:0] IU  = 32'h1 << `CTL_IU_EN;
  localparam logic [31:0] FRM = 32'h1 << `CTL_FRAME;
  localparam logic [31:0] GO  = 32'h1 << `CTL_START;
  localparam logic [31:0] DMA = 32'h1 << `CTL_DMA_EN;
  localparam logic [31:0] SWE = 32'h1 << `CTL_STAT_EN;
  localparam logic [31:0] CH  = 32'h0000_3012;
  localparam int          PER_EV = 6;
  logic        clk, rst, we, cyc, stb, ack, conv_clk, trig, adc_done;
  logic        pci_req, pci_ack, pci_abort, abort_en;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, pci_addr, pci_data, r, base, sbase, stat_word;
  logic [3:0]  sel, adc_conv, pci_be;
  logic [63:0] adc_data;
  logic [11:0] regs [9] = '{12'h124, 12'h12c, 12'h130, 12'h134, 12'h140, 12'h144,
                            12'h148, 12'h14c, 12'h200};
  int          mismatches, check_count, pulses, n, stat_writes, sample_writes;
  logic [3:0]  be_exp = 4'h3;

  adc_seq_dma i_adc_seq_dma (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat),
    .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack),
    .conv_clk_i(conv_clk), .frame_trig_i(trig), .adc_done_i(adc_done),
    .adc_data_i(adc_data), .adc_conv_o(adc_conv), .pci_req_o(pci_req),
    .pci_addr_o(pci_addr), .pci_data_o(pci_data), .pci_be_o(pci_be),
    .pci_ack_i(pci_ack), .pci_abort_i(pci_abort));
  host_ram_model i_host_ram_model (.clk_i(clk), .rst_i(rst), .req_i(pci_req),
    .addr_i(pci_addr), .data_i(pci_data), .abort_en_i(abort_en), .stat_base_i(sbase),
    .ack_o(pci_ack), .abort_o(pci_abort), .stat_word_o(stat_word),
    .stat_writes_o(stat_writes), .sample_writes_o(sample_writes));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    adc_done <= |adc_conv;
    adc_data <= {$urandom, $urandom};
    pulses <= pulses + $countones(adc_conv);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Sample writes alternate halves of a word, starting at an aligned buffer base
  always @(posedge clk) begin
    if (pci_ack && pci_addr != sbase) begin
      chk("byte enables", {28'h0, be_exp}, {28'h0, pci_be});
      be_exp <= ~be_exp;
    end
  end

  // Request held from just after an edge until the edge at which ack is seen high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, r & m);
  endtask

  task automatic waitreg(input string nm, input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] e);
    int k;
    k = 0;
    do begin
      wb(1'b0, a, 32'h0);
      k++;
    end while ((r & m) !== e && k < 300);
    chk(nm, e, r & m);
  endtask

  task automatic pulse_conv(input int gap);
    conv_clk <= 1'b1;
    @(posedge clk);
    conv_clk <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  task automatic results;
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(8 * 40000);
    mismatches++;
    results();
  end

  initial begin
    rst = 1'b1; we = 0; cyc = 0; stb = 0; adr = '0; wdat = '0; sel = 4'hf;
    conv_clk = 0; trig = 0; abort_en = 0; mismatches = 0; check_count = 0;
    pulses = 0;
    void'($urandom(32'h0d7f));
    base = $urandom & 32'hffff_f000;
    sbase = base + 32'h8000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) rdchk("reset value", regs[i], 32'hffff_ffff, 32'h0);
    wb(1'b1, `OFS_STAT_BASE, sbase);
    rdchk("status base", `OFS_STAT_BASE, 32'hffff_ffff, sbase);
    wb(1'b1, `OFS_TALLY, 32'h5);
    rdchk("read only tally", `OFS_TALLY, 32'hffff_ffff, 32'h0);
    n = $urandom_range(4, 1);
    wb(1'b1, `OFS_CHANNELS, CH);
    wb(1'b1, `OFS_NUM_CONV, n);
    wb(1'b1, `OFS_BUF_BASE, base);
    wb(1'b1, `OFS_CONTROL, IU | DMA | SWE);
    wb(1'b1, `OFS_BUF_LEN, 32'h0);
    rdchk("zero length", `OFS_STATUS, 32'h0003_0000, 32'h0001_0000);
    wb(1'b1, `OFS_BUF_LEN, 32'h0000_1000);
    rdchk("cause cleared", `OFS_STATUS, 32'h0073_0000, 32'h0002_0000);
    wb(1'b1, `OFS_BUF_BASE, base + 32'h100);
    wb(1'b1, `OFS_CONTROL, IU | DMA | SWE | GO);
    rdchk("active", `OFS_STATUS, 32'h4, 32'h4);
    rdchk("tally cleared", `OFS_TALLY, 32'h0fff_ffff, 32'h0);
    repeat (n) pulse_conv(60);
    waitreg("block end", `OFS_STATUS, 32'h0071_0000, 32'h0021_0000);
    rdchk("pointer", `OFS_WPTR, 32'hffff_ffff, base + 2 * PER_EV * n);
    rdchk("tally", `OFS_TALLY, 32'h0fff_ffff, n);
    rdchk("stopped", `OFS_STATUS, 32'h4, 32'h0);
    chk("pulses", PER_EV * n, pulses);
    rdchk("fill", `OFS_FILL, 32'hffff_ffff, 32'h0);
    chk("status word", {4'h2, 28'(2 * PER_EV * n)}, stat_word);
    wb(1'b1, `OFS_BUF_LEN, 32'h4);
    wb(1'b1, `OFS_CONTROL, IU | DMA | SWE | GO);
    pulse_conv(60);
    waitreg("buffer end", `OFS_STATUS, 32'h0071_0000, 32'h0011_0000);
    chk("end word", {4'h1, 28'h4}, stat_word);
    chk("word count", 2, stat_writes);
    rdchk("pointer", `OFS_WPTR, 32'hffff_ffff, base + 32'h104);
    rdchk("fill left", `OFS_FILL, 32'hffff_ffff, 2 * (PER_EV - 2));
    wb(1'b1, `OFS_CONTROL, IU | SWE);
    rdchk("dma off", `OFS_STATUS, 32'h0003_0000, 32'h0);
    abort_en <= 1'b1;
    wb(1'b1, `OFS_CONTROL, IU | DMA | SWE);
    wb(1'b1, `OFS_BUF_LEN, 32'h40);
    waitreg("abort", `OFS_STATUS, 32'h0007_0000, 32'h0004_0000);
    wb(1'b1, `OFS_CONTROL, IU);
    rdchk("abort cleared", `OFS_STATUS, 32'h0005_0000, 32'h0);
    wb(1'b1, `OFS_NUM_CONV, 32'h0);
    wb(1'b1, `OFS_CONTROL, IU | GO);
    pulse_conv(2);
    pulse_conv(20);
    waitreg("conv error", `OFS_STATUS, 32'h20, 32'h20);
    wb(1'b1, `OFS_CONTROL, 32'h0);
    rdchk("iu off", `OFS_STATUS, 32'h71, 32'h0);
    wb(1'b1, `OFS_NUM_CONV, 32'h5);
    wb(1'b1, `OFS_CONTROL, IU | FRM);
    rdchk("iu idle", `OFS_STATUS, 32'h1, 32'h1);
    repeat (2) begin
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
    end
    waitreg("frame error", `OFS_STATUS, 32'h40, 32'h40);
    wb(1'b1, `OFS_CONTROL, 32'h0);
    rdchk("frame cleared", `OFS_STATUS, 32'h41, 32'h0);
    results();
  end
endmodule
